// *** verilog/dual_timer_pkg.sv ***
// Shared constants, register map and carrier types of the dual 8-bit timer/counter.
`default_nettype none
package dual_timer_pkg;

  // Register byte offsets on the APB.
  localparam logic [7:0] OFS_CTRL_LO  = 8'h00;
  localparam logic [7:0] OFS_CTRL_HI  = 8'h04;
  localparam logic [7:0] OFS_CMP_LO   = 8'h08;
  localparam logic [7:0] OFS_CMP_HI   = 8'h0C;
  localparam logic [7:0] OFS_DUTY_LO  = 8'h10;
  localparam logic [7:0] OFS_DUTY_HI  = 8'h14;
  localparam logic [7:0] OFS_SYSCFG   = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1C;

  // Field positions in the system configuration register.
  localparam int unsigned SYSCFG_TAP_SEL_BIT = 0;
  localparam int unsigned SYSCFG_LOW_PWR_BIT = 1;

  // Field positions in the status register.
  localparam int unsigned STATUS_CNT_HI_LSB = 8;
  localparam int unsigned STATUS_TFF_LSB    = 16;

  // Operating mode encodings of the counter mode field.
  localparam logic [2:0] MODE_TIMER8   = 3'h0;
  localparam logic [2:0] MODE_DIVIDER  = 3'h1;
  localparam logic [2:0] MODE_PWM8     = 3'h2;
  localparam logic [2:0] MODE_RSVD     = 3'h3;
  localparam logic [2:0] MODE_TIMER16  = 3'h4;
  localparam logic [2:0] MODE_WARMUP   = 3'h5;
  localparam logic [2:0] MODE_PWM16    = 3'h6;
  localparam logic [2:0] MODE_PPG16    = 3'h7;

  // Clock select encodings.
  localparam logic [2:0] CK_SLOW_TAP   = 3'h0;
  localparam logic [2:0] CK_DIV7       = 3'h1;
  localparam logic [2:0] CK_DIV5       = 3'h2;
  localparam logic [2:0] CK_DIV3       = 3'h3;
  localparam logic [2:0] CK_LOW_CLK    = 3'h4;
  localparam logic [2:0] CK_DIV1       = 3'h5;
  localparam logic [2:0] CK_FAST       = 3'h6;
  localparam logic [2:0] CK_PIN        = 3'h7;

  // Prescaler widths: a free divider on the fast clock and one on the slow ticks.
  localparam int unsigned PRE_FAST_W = 11;
  localparam int unsigned PRE_SLOW_W = 3;

  // Reset values.
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  CMP_RST    = 8'hFF;
  localparam logic [7:0]  DUTY_RST   = 8'hFF;
  localparam logic [1:0]  SYSCFG_RST = 2'h0;
  localparam logic [31:0] RDATA_RST  = 32'h0000_0000;

  // Control register layout of one channel.
  typedef struct packed {
    logic       toggle_initial_bit;
    logic [2:0] clk_sel;
    logic       start;
    logic [2:0] counter_mode_field;
  } ctrl_t;

  // One-cycle tick pulses from the prescaler.
  typedef struct packed {
    logic div11;
    logic div7;
    logic div5;
    logic div3;
    logic div1;
    logic low_clk;
    logic low_div3;
  } tick_t;

endpackage : dual_timer_pkg
`default_nettype wire

// *** verilog/pin_edge_sync.sv ***
// Two-stage synchroniser with falling-edge detection for one count input pin.
`timescale 1ns/1ns
`default_nettype none
module pin_edge_sync (
  // Clock and reset.
  input  wire logic CLK_SYS,
  input  wire logic RST,
  input  wire logic CE,
  // Pin and detected edge.
  input  wire logic PIN,
  output logic      FALL
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // The first stage feeds only the second, so nothing sees a metastable value.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else if (CE) begin
      meta_q <= PIN;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // A falling edge is high on the older sample and low on the newer one.
  assign FALL = last_q & ~sync_q;

endmodule : pin_edge_sync
`default_nettype wire

// *** verilog/tick_prescaler.sv ***
// Free-running prescaler producing one-cycle tick pulses from the fast and slow clocks.
`timescale 1ns/1ns
`default_nettype none
module tick_prescaler (
  // Clock and reset.
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST,
  input  wire logic                 CE,
  // Slow clock tick, one system cycle per slow period.
  input  wire logic                 LOW_TICK,
  input  wire logic                 LOW_PWR,
  // Prescaled ticks.
  output dual_timer_pkg::tick_t     TICKS
);

  logic [dual_timer_pkg::PRE_FAST_W-1:0] fast_q;
  logic [dual_timer_pkg::PRE_SLOW_W-1:0] slow_q;
  logic                                  fast_run;

  // The fast clock is taken as stopped in the low-frequency power modes.
  assign fast_run = CE & ~LOW_PWR;

  // Fast divider; a tap ticks when all bits below it are ones.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      fast_q <= '0;
    end else if (fast_run) begin
      fast_q <= fast_q + 1'b1;
    end
  end

  // Slow divider advances only on slow clock ticks.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      slow_q <= '0;
    end else if (CE && LOW_TICK) begin
      slow_q <= slow_q + 1'b1;
    end
  end

  // Tap pulses at the divided rates.
  assign TICKS.div11    = fast_run & (&fast_q);
  assign TICKS.div7     = fast_run & (&fast_q[6:0]);
  assign TICKS.div5     = fast_run & (&fast_q[4:0]);
  assign TICKS.div3     = fast_run & (&fast_q[2:0]);
  assign TICKS.div1     = fast_run & fast_q[0];
  assign TICKS.low_clk  = CE & LOW_TICK;
  assign TICKS.low_div3 = CE & LOW_TICK & (&slow_q);

endmodule : tick_prescaler
`default_nettype wire

// *** verilog/dual_timer.sv ***
// Top of the dual 8-bit timer, event counter and programmable divider with APB registers.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module dual_timer (
  // Clock, reset and enable.
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        CE,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Slow clock tick, high for one cycle per slow clock period.
  input  wire logic        LOW_FREQ_CLOCK_TICK,
  // Count inputs, divider outputs and match interrupts; index 0 is the lower counter.
  input  wire logic [1:0]  COUNT_INPUT_PIN,
  output logic [1:0]       DIVIDER_OUT_PIN,
  output logic [1:0]       COUNTER_MATCH_IRQ
);

  // Register state.
  dual_timer_pkg::ctrl_t timer_control_reg_q [2];
  logic [7:0]            match_compare_reg_q [2];
  logic [7:0]            pulse_duty_reg_q    [2];
  logic [1:0]            syscfg_q;
  logic [31:0]           prdata_q;
  logic                  pslverr_q;

  // Counter state.
  logic [7:0]            cnt_q [2];
  logic [7:0]            cnt_d [2];
  logic [1:0]            tff_q;
  logic [1:0]            tff_d;
  logic [1:0]            pin_out_q;
  logic [1:0]            irq_q;
  logic [1:0]            match;

  // Decoded control.
  logic                  divider_tap_select;
  logic                  low_power;
  logic                  cascade;
  logic [1:0]            run8;
  logic [1:0]            is_div;
  logic                  run16;
  logic [1:0]            src_tick;
  logic [1:0]            pin_fall;
  logic [15:0]           cnt16_next;
  logic [7:0]            cnt8_next [2];
  dual_timer_pkg::tick_t ticks;

  // APB strobes.
  logic                  wr_en;
  logic                  setup;
  logic [1:0]            ctrl_wr;
  logic [1:0]            cmp_wr;
  logic [1:0]            duty_wr;
  logic                  cfg_wr;
  logic                  addr_hit;

  assign divider_tap_select = syscfg_q[dual_timer_pkg::SYSCFG_TAP_SEL_BIT];
  assign low_power          = syscfg_q[dual_timer_pkg::SYSCFG_LOW_PWR_BIT];

  // Prescaler shared by both counters.
  tick_prescaler u_prescaler (
    .CLK_SYS  (CLK_SYS),
    .RST      (RST),
    .CE       (CE),
    .LOW_TICK (LOW_FREQ_CLOCK_TICK),
    .LOW_PWR  (low_power),
    .TICKS    (ticks)
  );

  // Count input synchronisers, one per counter.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      pin_edge_sync u_sync (
        .CLK_SYS (CLK_SYS),
        .RST     (RST),
        .CE      (CE),
        .PIN     (COUNT_INPUT_PIN[g]),
        .FALL    (pin_fall[g])
      );
    end
  endgenerate

  // Picks the tick pulse for a clock select; the slowest tap switches to the slow clock
  // when the tap select is set or the fast clock is stopped.
  function automatic logic pick_tick(input logic [2:0] sel, input dual_timer_pkg::tick_t t,
                                     input logic fall, input logic slow_tap);
    logic r;
    r = 1'b0;
    case (sel)
      dual_timer_pkg::CK_SLOW_TAP: r = slow_tap ? t.low_div3 : t.div11;
      dual_timer_pkg::CK_DIV7:     r = t.div7;
      dual_timer_pkg::CK_DIV5:     r = t.div5;
      dual_timer_pkg::CK_DIV3:     r = t.div3;
      dual_timer_pkg::CK_LOW_CLK:  r = t.low_clk;
      dual_timer_pkg::CK_DIV1:     r = t.div1;
      dual_timer_pkg::CK_FAST:     r = ~low_power;
      dual_timer_pkg::CK_PIN:      r = fall;
      default:                     r = 1'b0;
    endcase
    return r;
  endfunction : pick_tick

  // Mode decode: the upper counter's mode field with its top bit set joins both halves.
  always_comb begin
    cascade = timer_control_reg_q[1].counter_mode_field[2];
    for (int j = 0; j < 2; j++) begin
      is_div[j] = timer_control_reg_q[j].counter_mode_field == dual_timer_pkg::MODE_DIVIDER;
      run8[j]   = timer_control_reg_q[j].start &&
                  (timer_control_reg_q[j].counter_mode_field == dual_timer_pkg::MODE_TIMER8 ||
                   is_div[j]);
    end
    run8[0] = run8[0] & ~cascade;
    // Only the 16-bit timer/event and warm-up modes run; the 16-bit pulse modes are held.
    run16 = timer_control_reg_q[1].start &&
            (timer_control_reg_q[1].counter_mode_field == dual_timer_pkg::MODE_TIMER16 ||
             timer_control_reg_q[1].counter_mode_field == dual_timer_pkg::MODE_WARMUP);
  end

  // Source ticks; when cascaded the lower counter's select drives the whole counter.
  always_comb begin
    for (int j = 0; j < 2; j++) begin
      src_tick[j] = CE & pick_tick(timer_control_reg_q[j].clk_sel, ticks, pin_fall[j],
                                   divider_tap_select | low_power);
    end
    if (cascade) begin
      src_tick[1] = src_tick[0];
    end
  end

  // Next counts and match detection; the compare register is read live, unbuffered.
  always_comb begin
    cnt16_next = {cnt_q[1], cnt_q[0]} + 16'h0001;
    for (int j = 0; j < 2; j++) begin
      cnt8_next[j] = cnt_q[j] + 8'h01;
      cnt_d[j]     = cnt_q[j];
      match[j]     = 1'b0;
    end
    if (cascade) begin
      if (!run16) begin
        cnt_d[0] = 8'h00;
        cnt_d[1] = 8'h00;
      end else if (src_tick[1]) begin
        if (cnt16_next == {match_compare_reg_q[1], match_compare_reg_q[0]}) begin
          match[1] = 1'b1;
          cnt_d[0] = 8'h00;
          cnt_d[1] = 8'h00;
        end else begin
          cnt_d[0] = cnt16_next[7:0];
          cnt_d[1] = cnt16_next[15:8];
        end
      end
    end else begin
      for (int j = 0; j < 2; j++) begin
        if (!run8[j]) begin
          cnt_d[j] = 8'h00;
        end else if (src_tick[j]) begin
          if (cnt8_next[j] == match_compare_reg_q[j]) begin
            match[j] = 1'b1;
            cnt_d[j] = 8'h00;
          end else begin
            cnt_d[j] = cnt8_next[j];
          end
        end
      end
    end
  end

  // Counter registers.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cnt_q[0] <= 8'h00;
      cnt_q[1] <= 8'h00;
    end else if (CE) begin
      cnt_q[0] <= cnt_d[0];
      cnt_q[1] <= cnt_d[1];
    end
  end

  // Toggle flip-flop: a stopped-state control write loads the initial value, a divider
  // match toggles it. Loading only while stopped keeps a running divider glitch-free.
  always_comb begin
    for (int j = 0; j < 2; j++) begin
      tff_d[j] = tff_q[j];
      if (ctrl_wr[j] && !PWDATA[3]) begin
        tff_d[j] = PWDATA[7];
      end else if (match[j] && is_div[j] && !cascade) begin
        tff_d[j] = ~tff_q[j];
      end
    end
  end

  // Toggle flip-flop, inverted pin copy and match pulse registers.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      tff_q     <= 2'h0;
      pin_out_q <= 2'h3;
      irq_q     <= 2'h0;
    end else if (CE) begin
      tff_q     <= tff_d;
      pin_out_q <= ~tff_d;
      irq_q     <= match;
    end
  end

  assign DIVIDER_OUT_PIN   = pin_out_q;
  assign COUNTER_MATCH_IRQ = irq_q;

  // APB decode; writes land in the access phase, reads are captured in the setup phase.
  assign setup   = PSEL & ~PENABLE;
  assign wr_en   = CE & PSEL & PENABLE & PWRITE;
  assign ctrl_wr = {wr_en && PADDR == dual_timer_pkg::OFS_CTRL_HI,
                    wr_en && PADDR == dual_timer_pkg::OFS_CTRL_LO};
  assign cmp_wr  = {wr_en && PADDR == dual_timer_pkg::OFS_CMP_HI,
                    wr_en && PADDR == dual_timer_pkg::OFS_CMP_LO};
  assign duty_wr = {wr_en && PADDR == dual_timer_pkg::OFS_DUTY_HI,
                    wr_en && PADDR == dual_timer_pkg::OFS_DUTY_LO};
  assign cfg_wr  = wr_en && PADDR == dual_timer_pkg::OFS_SYSCFG;

  // Known addresses; anything else answers with an error and zero data.
  always_comb begin
    case (PADDR)
      dual_timer_pkg::OFS_CTRL_LO, dual_timer_pkg::OFS_CTRL_HI,
      dual_timer_pkg::OFS_CMP_LO,  dual_timer_pkg::OFS_CMP_HI,
      dual_timer_pkg::OFS_DUTY_LO, dual_timer_pkg::OFS_DUTY_HI,
      dual_timer_pkg::OFS_SYSCFG,  dual_timer_pkg::OFS_STATUS: addr_hit = 1'b1;
      default:                                                 addr_hit = 1'b0;
    endcase
  end

  // Control, compare, duty and configuration registers.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      for (int j = 0; j < 2; j++) begin
        timer_control_reg_q[j] <= dual_timer_pkg::CTRL_RST;
        match_compare_reg_q[j] <= dual_timer_pkg::CMP_RST;
        pulse_duty_reg_q[j]    <= dual_timer_pkg::DUTY_RST;
      end
      syscfg_q <= dual_timer_pkg::SYSCFG_RST;
    end else begin
      for (int j = 0; j < 2; j++) begin
        if (ctrl_wr[j]) begin
          timer_control_reg_q[j] <= PWDATA[7:0];
        end
        if (cmp_wr[j]) begin
          match_compare_reg_q[j] <= PWDATA[7:0];
        end
        if (duty_wr[j]) begin
          pulse_duty_reg_q[j] <= PWDATA[7:0];
        end
      end
      if (cfg_wr) begin
        syscfg_q <= PWDATA[1:0];
      end
    end
  end

  // Read data and error captured at the setup cycle so the access phase needs no wait.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      prdata_q  <= dual_timer_pkg::RDATA_RST;
      pslverr_q <= 1'b0;
    end else if (CE && setup) begin
      pslverr_q <= ~addr_hit;
      case (PADDR)
        dual_timer_pkg::OFS_CTRL_LO: prdata_q <= {24'h000000, timer_control_reg_q[0]};
        dual_timer_pkg::OFS_CTRL_HI: prdata_q <= {24'h000000, timer_control_reg_q[1]};
        dual_timer_pkg::OFS_CMP_LO:  prdata_q <= {24'h000000, match_compare_reg_q[0]};
        dual_timer_pkg::OFS_CMP_HI:  prdata_q <= {24'h000000, match_compare_reg_q[1]};
        dual_timer_pkg::OFS_DUTY_LO: prdata_q <= {24'h000000, pulse_duty_reg_q[0]};
        dual_timer_pkg::OFS_DUTY_HI: prdata_q <= {24'h000000, pulse_duty_reg_q[1]};
        dual_timer_pkg::OFS_SYSCFG:  prdata_q <= {30'h00000000, syscfg_q};
        dual_timer_pkg::OFS_STATUS:  prdata_q <= {14'h0000, tff_q, cnt_q[1], cnt_q[0]};
        default:                     prdata_q <= dual_timer_pkg::RDATA_RST;
      endcase
    end
  end

  // The slave is always ready while enabled; a low enable stretches the access phase.
  assign PREADY  = CE;
  assign PRDATA  = prdata_q;
  assign PSLVERR = pslverr_q;

endmodule : dual_timer
`default_nettype wire

// *** dv/dual_timer_monitor.sv ***
// Port-level concurrent checks for the dual timer.
`timescale 1ns/1ns
`default_nettype none
module dual_timer_monitor (
  // Clock, reset and enable.
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic        CE,
  // APB slave.
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Timer pins.
  input wire logic        LOW_FREQ_CLOCK_TICK,
  input wire logic [1:0]  COUNT_INPUT_PIN,
  input wire logic [1:0]  DIVIDER_OUT_PIN,
  input wire logic [1:0]  COUNTER_MATCH_IRQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // Access phase, read access and write access qualifiers.
  logic acc;
  logic rd;
  logic wacc;
  assign acc  = PSEL && PENABLE;
  assign rd   = acc && !PWRITE;
  assign wacc = acc && PWRITE;

  AST_RST_VALUES: assert property ($fell(RST) |-> DIVIDER_OUT_PIN == 2'h3 && COUNTER_MATCH_IRQ == 2'h0)
    else $error("outputs not at reset values after release");
  AST_READY_ZERO_WAIT: assert property (acc |-> PREADY == CE)
    else $error("ready does not follow the clock enable");
  AST_UNMAPPED_ERR: assert property (acc && PADDR > 8'h1C |-> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (acc && PADDR <= 8'h1C && PADDR[1:0] == 2'h0 |-> !PSLVERR)
    else $error("mapped access refused");
  AST_NARROW_REG: assert property (rd && PADDR < dual_timer_pkg::OFS_SYSCFG |-> PRDATA[31:8] == 24'h00_0000)
    else $error("byte register reads wider than eight bits");
  AST_SYSCFG_BITS: assert property (rd && PADDR == dual_timer_pkg::OFS_SYSCFG |-> PRDATA[31:2] == 30'h0)
    else $error("configuration read has stray bits");
  // The toggle bits read back must be the inverse of the pins while the pins hold still.
  AST_STATUS_TFF: assert property (rd && PADDR == dual_timer_pkg::OFS_STATUS && $stable(DIVIDER_OUT_PIN)
    |-> PRDATA[17:16] == ~DIVIDER_OUT_PIN)
    else $error("status toggle bits disagree with divider pins");
  // A pin change not caused by a control write is a match, and the match pulse rises with it.
  AST_DIV0_IRQ: assert property ($changed(DIVIDER_OUT_PIN[0]) && !$past(wacc) |-> COUNTER_MATCH_IRQ[0])
    else $error("lower divider toggled without a match pulse");
  AST_DIV1_IRQ: assert property ($changed(DIVIDER_OUT_PIN[1]) && !$past(wacc) |-> COUNTER_MATCH_IRQ[1])
    else $error("upper divider toggled without a match pulse");

  // Main scenarios reached.
  COV_IRQ_LO: cover property ($rose(COUNTER_MATCH_IRQ[0]));
  COV_IRQ_HI: cover property ($rose(COUNTER_MATCH_IRQ[1]));
  COV_SLVERR: cover property (acc && PSLVERR);
  COV_DIV: cover property ($changed(DIVIDER_OUT_PIN));
endmodule : dual_timer_monitor
`default_nettype wire

// *** dv/event_source.sv ***
// Behavioural source of event pulses on the two count input pins.
`timescale 1ns/1ns
`default_nettype none
module event_source (
  // Clock.
  input wire logic       CLK_SYS,
  // Pins to pulse and the length of each level in cycles.
  input wire logic [1:0] GO,
  input wire logic [7:0] HOLD,
  // Pins and activity flag.
  output var logic [1:0] PIN,
  output var logic       BUSY
);
  // Pins idle high, so each request starts with a falling edge.
  initial PIN = 2'h3;
  initial BUSY = 1'b0;

  // One low then one high level per request; a short hold is stretched to two cycles.
  always begin : pulse_gen
    logic [1:0] m;
    int         h;
    @(posedge CLK_SYS);
    if (GO != 2'h0) begin
      m = GO;
      h = (HOLD < 8'h02) ? 2 : int'(HOLD);
      BUSY <= 1'b1;
      PIN  <= PIN & ~m;
      repeat (h) @(posedge CLK_SYS);
      PIN  <= PIN | m;
      repeat (h) @(posedge CLK_SYS);
      BUSY <= 1'b0;
    end
  end
endmodule : event_source
`default_nettype wire

// *** dv/dual_timer_bench.sv ***
// Self-checking bench for the dual timer.
`timescale 1ns/1ns
`default_nettype none
module dual_timer_bench;
  // Bench nets.
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        low_tick = 1'b0;
  logic [1:0]  low_cnt = 2'h0;
  logic [1:0]  ev_pin;
  logic [1:0]  ev_go = 2'h0;
  logic [7:0]  ev_hold = 8'h02;
  logic        ev_busy;
  logic [1:0]  div_pin;
  logic [1:0]  irq;
  int          irq_n [2] = '{0, 0};
  int          num_errors = 0;
  int          tests_run = 0;

  // The 8 ns system clock.
  always #4 clk_sys = ~clk_sys;

  // Slow clock tick once every four cycles, so slow periods stay short.
  always @(posedge clk_sys) begin
    low_cnt  <= low_cnt + 2'h1;
    low_tick <= low_cnt == 2'h3;
  end

  // Running tallies of match pulses.
  always @(posedge clk_sys) begin
    irq_n[0] <= irq_n[0] + int'(irq[0] === 1'b1);
    irq_n[1] <= irq_n[1] + int'(irq[1] === 1'b1);
  end

  dual_timer dual_timer_inst (
    .CLK_SYS(clk_sys), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LOW_FREQ_CLOCK_TICK(low_tick), .COUNT_INPUT_PIN(ev_pin), .DIVIDER_OUT_PIN(div_pin),
    .COUNTER_MATCH_IRQ(irq)
  );

  event_source event_source_inst (
    .CLK_SYS(clk_sys), .GO(ev_go), .HOLD(ev_hold), .PIN(ev_pin), .BUSY(ev_busy)
  );

  task automatic close_out();
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; the request holds until ready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, err});
  endtask : rdc

  function automatic logic [31:0] cw(input logic t, input logic [2:0] s, input logic st, input logic [2:0] m);
    return {24'h0, t, s, st, m};
  endfunction : cw

  // Cycles between two match pulses of one channel.
  task automatic per(input logic ch, input int exp);
    int n;
    n = 0;
    while (irq[ch] !== 1'b1 && n < 9000) begin
      @(posedge clk_sys);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (irq[ch] !== 1'b1 && n < 9000);
    chk(n, exp);
  endtask : per

  task automatic run(input logic ch, input logic [2:0] s, input int c, input int p);
    wr({5'h0, ch, 2'h0}, 32'h0);
    wr({4'h0, 1'b1, ch, 2'h0}, 32'(c));
    wr({5'h0, ch, 2'h0}, cw(1'b0, s, 1'b1, dual_timer_pkg::MODE_TIMER8));
    per(ch, p);
  endtask : run

  task automatic t_reset();
    logic [31:0] rv [8];
    rv = '{32'h0, 32'h0, 32'hFF, 32'hFF, 32'hFF, 32'hFF, 32'h0, 32'h0};
    chk({30'h0, div_pin}, 32'h3);
    for (int i = 0; i < 8; i++) rdc(8'(4 * i), rv[i], 1'b0);
    rdc(8'h20, 32'h0, 1'b1);
    wr(8'h20, 32'hFF);
    wr(dual_timer_pkg::OFS_STATUS, 32'hFFFF);
    rdc(dual_timer_pkg::OFS_STATUS, 32'h0, 1'b0);
    wr(dual_timer_pkg::OFS_DUTY_LO, 32'hA5);
    rdc(dual_timer_pkg::OFS_DUTY_LO, 32'hA5, 1'b0);
  endtask : t_reset

  // Every clock source except the pin, both channels, top compare value included.
  task automatic t_taps();
    logic [2:0] s [8];
    int         c [8];
    int         p [8];
    s = '{3'h6, 3'h6, 3'h5, 3'h3, 3'h2, 3'h1, 3'h0, 3'h4};
    c = '{5, 255, 3, 2, 1, 1, 1, 2};
    p = '{5, 255, 6, 16, 32, 128, 2048, 8};
    for (int i = 0; i < 8; i++) run(i[0], s[i], c[i], p[i]);
    for (int j = 1; j < 3; j++) begin
      wr(dual_timer_pkg::OFS_SYSCFG, 32'(j));
      run(1'b0, dual_timer_pkg::CK_SLOW_TAP, 1, 32);
    end
    wr(dual_timer_pkg::OFS_SYSCFG, 32'h0);
  endtask : t_taps

  task automatic t_div();
    int   n;
    logic v;
    wr(8'h00, 32'h0);
    wr(8'h04, cw(1'b1, dual_timer_pkg::CK_FAST, 1'b0, dual_timer_pkg::MODE_DIVIDER));
    @(posedge clk_sys);
    chk({31'h0, div_pin[1]}, 32'h0);
    wr(8'h0C, 32'h4);
    wr(8'h04, cw(1'b0, dual_timer_pkg::CK_FAST, 1'b1, dual_timer_pkg::MODE_DIVIDER));
    per(1'b1, 4);
    v = div_pin[1];
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (div_pin[1] === v && n < 99);
    chk(n, 4);
    wr(8'h04, cw(1'b0, dual_timer_pkg::CK_FAST, 1'b0, dual_timer_pkg::MODE_DIVIDER));
    @(posedge clk_sys);
    chk({30'h0, div_pin}, 32'h3);
    rdc(dual_timer_pkg::OFS_STATUS, 32'h0, 1'b0);
  endtask : t_div

  task automatic pulse(input logic [7:0] h);
    ev_hold <= h;
    ev_go   <= 2'h3;
    @(posedge clk_sys);
    ev_go   <= 2'h0;
    @(posedge clk_sys);
    while (ev_busy !== 1'b0) @(posedge clk_sys);
  endtask : pulse

  // Both channels count pin edges, the fastest legal and a slower rate.
  task automatic t_event();
    int a;
    int b;
    wr(8'h08, 32'h3);
    wr(8'h0C, 32'h2);
    wr(8'h00, cw(1'b0, dual_timer_pkg::CK_PIN, 1'b1, dual_timer_pkg::MODE_TIMER8));
    wr(8'h04, cw(1'b0, dual_timer_pkg::CK_PIN, 1'b1, dual_timer_pkg::MODE_TIMER8));
    a = irq_n[0];
    b = irq_n[1];
    for (int i = 0; i < 5; i++) pulse(i < 3 ? 8'h02 : 8'h05);
    repeat (4) @(posedge clk_sys);
    chk(irq_n[0] - a, 1);
    chk(irq_n[1] - b, 2);
    rdc(dual_timer_pkg::OFS_STATUS, 32'h0000_0102, 1'b0);
  endtask : t_event

  // A smaller compare written mid-count must end the period early.
  task automatic t_cmp();
    int n;
    wr(8'h08, 32'hFF);
    wr(8'h00, cw(1'b0, dual_timer_pkg::CK_FAST, 1'b1, dual_timer_pkg::MODE_TIMER8));
    wr(8'h08, 32'h10);
    n = 0;
    while (irq[0] !== 1'b1 && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    chk({31'h0, n < 20}, 32'h1);
  endtask : t_cmp

  // A low clock enable freezes the count: only three enabled edges lie between the two reads.
  task automatic t_freeze();
    logic [31:0] r0;
    logic [31:0] r1;
    logic        e;
    wr(8'h08, 32'hFF);
    apb(1'b0, dual_timer_pkg::OFS_STATUS, 32'h0, r0, e);
    ce <= 1'b0;
    repeat (10) @(posedge clk_sys);
    ce <= 1'b1;
    apb(1'b0, dual_timer_pkg::OFS_STATUS, 32'h0, r1, e);
    chk(r1 - r0, 32'h3);
  endtask : t_freeze

  task automatic t_modes();
    logic [2:0] m [4];
    int         a;
    m = '{3'h2, 3'h3, 3'h6, 3'h7};
    wr(8'h08, 32'h1);
    wr(8'h0C, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, cw(1'b0, dual_timer_pkg::CK_FAST, 1'b1, m[i]));
      wr(8'h04, cw(1'b0, dual_timer_pkg::CK_FAST, 1'b1, m[i]));
      a = irq_n[0] + irq_n[1];
      repeat (20) @(posedge clk_sys);
      chk(irq_n[0] + irq_n[1] - a, 0);
    end
  endtask : t_modes

  // Cascade: source from the lower select, upper select set to a slow tap.
  task automatic t_casc();
    int a;
    wr(8'h08, 32'h2);
    wr(8'h0C, 32'h1);
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, cw(1'b0, dual_timer_pkg::CK_FAST, 1'b0, dual_timer_pkg::MODE_TIMER8));
      wr(8'h04, cw(1'b0, dual_timer_pkg::CK_SLOW_TAP, 1'b1, 3'h4 + 3'(i)));
      a = irq_n[0];
      per(1'b1, 258);
      chk(irq_n[0] - a, 0);
    end
  endtask : t_casc

  // Main sequence.
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_taps();
    t_div();
    t_event();
    t_cmp();
    t_freeze();
    t_modes();
    t_casc();
    close_out();
  end

  // Watchdog, several times the expected run length.
  initial begin
    #480000;
    num_errors++;
    close_out();
  end
endmodule : dual_timer_bench

bind dual_timer dual_timer_monitor dual_timer_monitor_inst (
  .CLK_SYS, .RST, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
  .LOW_FREQ_CLOCK_TICK, .COUNT_INPUT_PIN, .DIVIDER_OUT_PIN, .COUNTER_MATCH_IRQ
);
`default_nettype wire
